// [rtl/rmbc_pkg.sv]
`default_nettype none
package rmbc_pkg;
  // Register word offsets (byte addresses, one aligned word each).
  localparam logic [7:0] RMBC_REG_CTRL = 8'h00;
  localparam logic [7:0] RMBC_REG_RT_NOM0 = 8'h04;
  localparam logic [7:0] RMBC_REG_RT_NOM1 = 8'h08;
  localparam logic [7:0] RMBC_REG_RT_NOM2 = 8'h0c;
  localparam logic [7:0] RMBC_REG_BC_NOM0 = 8'h10;
  localparam logic [7:0] RMBC_REG_BC_NOM1 = 8'h14;
  localparam logic [7:0] RMBC_REG_BC_NOM2 = 8'h18;
  localparam logic [7:0] RMBC_REG_VAR0 = 8'h1c;
  localparam logic [7:0] RMBC_REG_VAR1 = 8'h20;
  localparam logic [7:0] RMBC_REG_CFG_CMP0 = 8'h24;
  localparam logic [7:0] RMBC_REG_CFG_CMP1 = 8'h28;
  localparam logic [7:0] RMBC_REG_OPTS = 8'h2c;
  localparam logic [7:0] RMBC_REG_STATUS = 8'h30;
  localparam logic [7:0] RMBC_REG_WORD4 = 8'h34;
  localparam logic [7:0] RMBC_REG_CMP_IN = 8'h38;

  // CTRL bits: write-one pulses.
  localparam int RMBC_CTRL_START = 0;
  localparam int RMBC_CTRL_DONE = 1;

  // OPTS fields.
  localparam int RMBC_OPT_BUSY_SRC = 0;
  localparam int RMBC_OPT_RX_CONT = 1;
  localparam int RMBC_OPT_RED_OK = 2;
  localparam int RMBC_OPT_RED_SEL_LO = 4;
  localparam int RMBC_OPT_FILL_LO = 8;
  localparam int RMBC_OPT_AUTO = 14;
  localparam int RMBC_OPT_SIMUL = 15;

  // Fourth data word field positions.
  localparam int RMBC_W4_TC = 0;
  localparam int RMBC_W4_DIS_LO = 4;
  localparam int RMBC_W4_EN_LO = 6;
  localparam int RMBC_W4_LV_LO = 8;
  localparam int RMBC_W4_FILL_LO = 10;
  localparam logic [15:0] RMBC_MASK_FILL = 16'hfc00;
  localparam logic [15:0] RMBC_MASK_EN = 16'h00c0;
  localparam logic [15:0] RMBC_MASK_DIS = 16'h0030;
  localparam logic [15:0] RMBC_MASK_TC = 16'h0001;

  localparam logic [1:0] RMBC_TC_END = 2'b00;
  localparam logic [1:0] RMBC_TC_XFER = 2'b10;
  localparam int RMBC_SW_BUSY_BIT = 3;
  localparam int RMBC_DW_BUSY_BIT = 15;
  localparam logic [3:0] RMBC_RED_LIMIT = 4'h8;
  localparam logic [15:0] RMBC_OPTS_RESET = 16'h0000;

  // Kind of control message to build.
  typedef enum logic [1:0]
  {
    RMBC_MSG_FIRST_LOAD,
    RMBC_MSG_END_LOAD,
    RMBC_MSG_END_VERIFY,
    RMBC_MSG_BC_TAKEOVER
  } rmbc_msg_t;

  typedef struct packed
  {
    logic busy_src;
    logic rx_cont;
    logic red_ok;
    logic [3:0] red_sel;
    logic [5:0] bc_fill;
    logic auto_mode;
    logic simul;
  } rmbc_opts_t;

  // Response from the bus front end.
  typedef struct packed
  {
    logic valid;
    logic is_activity;
    logic is_receive;
    logic [15:0] status_word;
    logic [15:0] data_word;
  } rmbc_resp_t;
endpackage
`default_nettype wire

// [rtl/rmbc_ctl.sv]
`default_nettype none
module rmbc_ctl
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic patch_exists,
  input wire logic full_exists,
  input wire logic hdr_valid,
  input wire logic [1:0] hdr_tc,
  input wire logic msg_req,
  input wire rmbc_pkg::rmbc_msg_t msg_kind,
  input wire logic act_as_bc,
  input wire logic is_verify,
  output logic [15:0] nom_word [3],
  output logic [15:0] word4,
  input wire rmbc_pkg::rmbc_resp_t resp,
  input wire logic bus_fail,
  output logic rt_busy,
  output logic discard_data,
  output logic resend_rx,
  output logic use_redundant,
  output logic [3:0] red_conn,
  output logic file_patch,
  output logic file_full,
  output logic need_reprog,
  output logic busy_active
);
  import rmbc_pkg::*;

  logic [15:0] rt_nom [3];
  logic [15:0] bc_nom [3];
  logic [15:0] ctl_var [2];
  logic [15:0] cfg_cmp [2];
  logic [15:0] cmp_in [2];
  logic [15:0] opts_reg;
  rmbc_opts_t opts_live;
  rmbc_opts_t held;
  logic [15:0] h_rt_nom [3];
  logic [15:0] h_bc_nom [3];
  logic [15:0] h_var [2];
  logic active;
  logic second_area;
  logic first_load_sent;
  logic switched;
  logic rx_pending;
  logic [1:0] last_tc;
  logic [15:0] var_sel;
  logic [15:0] next_word4;
  logic start_p;
  logic done_p;
  logic sw_busy;
  logic dw_busy;

  assign opts_live = rmbc_opts_t'({opts_reg[RMBC_OPT_BUSY_SRC],
    opts_reg[RMBC_OPT_RX_CONT], opts_reg[RMBC_OPT_RED_OK],
    opts_reg[RMBC_OPT_RED_SEL_LO +: 4], opts_reg[RMBC_OPT_FILL_LO +: 6],
    opts_reg[RMBC_OPT_AUTO], opts_reg[RMBC_OPT_SIMUL]});
  assign start_p = wr && addr == RMBC_REG_CTRL && wdata[RMBC_CTRL_START];
  assign done_p = wr && addr == RMBC_REG_CTRL && wdata[RMBC_CTRL_DONE];

  // Software-visible table; writes at any time only reach the
  // block at the next start, so a mid-load write cannot disturb a message.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      opts_reg <= RMBC_OPTS_RESET;
      for (int i = 0; i < 3; i++)
      begin
        rt_nom[i] <= 16'h0000;
        bc_nom[i] <= 16'h0000;
      end
      for (int i = 0; i < 2; i++)
      begin
        ctl_var[i] <= 16'h0000;
        cfg_cmp[i] <= 16'h0000;
        cmp_in[i] <= 16'h0000;
      end
    end
    else if (wr)
    begin
      if (addr == RMBC_REG_RT_NOM0)
        rt_nom[0] <= wdata;
      else if (addr == RMBC_REG_RT_NOM1)
        rt_nom[1] <= wdata;
      else if (addr == RMBC_REG_RT_NOM2)
        rt_nom[2] <= wdata;
      else if (addr == RMBC_REG_BC_NOM0)
        bc_nom[0] <= wdata;
      else if (addr == RMBC_REG_BC_NOM1)
        bc_nom[1] <= wdata;
      else if (addr == RMBC_REG_BC_NOM2)
        bc_nom[2] <= wdata;
      else if (addr == RMBC_REG_VAR0)
        ctl_var[0] <= wdata;
      else if (addr == RMBC_REG_VAR1)
        ctl_var[1] <= wdata;
      else if (addr == RMBC_REG_CFG_CMP0)
        cfg_cmp[0] <= wdata;
      else if (addr == RMBC_REG_CFG_CMP1)
        cfg_cmp[1] <= wdata;
      else if (addr == RMBC_REG_OPTS)
        opts_reg <= wdata;
      else if (addr == RMBC_REG_CMP_IN)
        cmp_in[0] <= wdata;
      else if (addr == RMBC_REG_CMP_IN + 8'h04)
        cmp_in[1] <= wdata;
    end
  end

  // Holding copies latched at start.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      active <= 1'b0;
      held <= '0;
      for (int i = 0; i < 3; i++)
      begin
        h_rt_nom[i] <= 16'h0000;
        h_bc_nom[i] <= 16'h0000;
      end
      h_var[0] <= 16'h0000;
      h_var[1] <= 16'h0000;
    end
    else if (start_p && !active)
    begin
      active <= 1'b1;
      held <= opts_live;
      h_rt_nom <= rt_nom;
      h_bc_nom <= bc_nom;
      h_var <= ctl_var;
    end
    else if (done_p)
      active <= 1'b0;
  end

  // File choice and reprogramming need.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      file_patch <= 1'b0;
      file_full <= 1'b0;
      need_reprog <= 1'b0;
    end
    else if (start_p && !active)
    begin
      // Patch entry always wins when present.
      file_patch <= patch_exists;
      file_full <= !patch_exists && full_exists;
      if (opts_live.auto_mode)
        need_reprog <= cmp_in[0] != cfg_cmp[0] ||
          cmp_in[1] != cfg_cmp[1];
      else
        need_reprog <= 1'b1;
    end
  end

  // Track headers, area and first message.
  always_ff @(posedge clk_sys)
  begin
    if (reset || (start_p && !active))
    begin
      last_tc <= 2'b11;
      second_area <= 1'b0;
      first_load_sent <= 1'b0;
    end
    else
    begin
      if (hdr_valid)
        last_tc <= hdr_tc;
      // Each end-of-load message opens the next load, whose first message
      // must carry the area enables again.
      if (msg_req && msg_kind == RMBC_MSG_FIRST_LOAD)
        first_load_sent <= 1'b1;
      else if (msg_req && msg_kind == RMBC_MSG_END_LOAD)
        first_load_sent <= 1'b0;
      if (msg_req && held.simul && !is_verify &&
          msg_kind == RMBC_MSG_END_LOAD &&
          (last_tc == RMBC_TC_END || last_tc == RMBC_TC_XFER))
        second_area <= 1'b1;
    end
  end

  assign var_sel = second_area ? h_var[1] : h_var[0];

  always_comb
  begin
    next_word4 = var_sel & RMBC_MASK_FILL;
    case (msg_kind)
      RMBC_MSG_FIRST_LOAD:
        if (!is_verify && !first_load_sent)
          next_word4 = next_word4 | (var_sel & RMBC_MASK_EN);
      RMBC_MSG_END_LOAD:
        if (!is_verify)
          next_word4 = next_word4 | (var_sel & RMBC_MASK_DIS);
      RMBC_MSG_END_VERIFY:
        // Code 10 leaves bits 0-9 clear; only 00 passes the transfer bit.
        if (last_tc == RMBC_TC_END)
          next_word4 = next_word4 | (var_sel & RMBC_MASK_TC);
      RMBC_MSG_BC_TAKEOVER:
        next_word4 = {held.bc_fill, 10'h000};
      default:
        next_word4 = 16'h0000;
    endcase
    // End-of-load and verify messages never carry bits 8 and 9.
    next_word4[RMBC_W4_LV_LO +: 2] = 2'b00;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      word4 <= 16'h0000;
      for (int i = 0; i < 3; i++)
        nom_word[i] <= 16'h0000;
    end
    else if (msg_req)
    begin
      word4 <= next_word4;
      for (int i = 0; i < 3; i++)
        nom_word[i] <= act_as_bc ? h_rt_nom[i] : h_bc_nom[i];
    end
  end

  // Busy tracking.
  assign sw_busy = resp.status_word[RMBC_SW_BUSY_BIT];
  assign dw_busy = resp.data_word[RMBC_DW_BUSY_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rt_busy <= 1'b0;
      discard_data <= 1'b0;
      rx_pending <= 1'b0;
      resend_rx <= 1'b0;
    end
    else
    begin
      resend_rx <= 1'b0;
      if (start_p && !active)
      begin
        // Data-flag units start out presumed busy.
        rt_busy <= !opts_live.busy_src;
        rx_pending <= 1'b0;
        discard_data <= 1'b0;
      end
      else if (resp.valid)
      begin
        discard_data <= sw_busy;
        if (sw_busy)
        begin
          rt_busy <= 1'b1;
          if (resp.is_receive)
            rx_pending <= 1'b1;
        end
        else if (!held.busy_src && resp.is_activity)
          rt_busy <= dw_busy;
        else if (held.busy_src)
          rt_busy <= 1'b0;
        if (!sw_busy && (held.busy_src || (resp.is_activity && !dw_busy))
            && rx_pending)
        begin
          rx_pending <= 1'b0;
          resend_rx <= !held.rx_cont;
        end
      end
    end
  end

  // Redundant bus choice.
  always_ff @(posedge clk_sys)
  begin
    if (reset || (start_p && !active))
      switched <= 1'b0;
    else if (bus_fail && held.red_ok && !switched)
      switched <= 1'b1;
  end

  always_comb
  begin
    red_conn = 4'h0;
    if (held.red_ok && ((held.red_sel >= 4'h1 && held.red_sel <= 4'h5) ||
        (held.red_sel >= 4'h9 && held.red_sel <= 4'hc)))
      red_conn = held.red_sel;
  end

  // One switch per transaction, for selectors 1-5 and 9-c only; switching back to a bus
  // that has already failed would only trade one fault for another.
  assign use_redundant = red_conn != 4'h0 && switched;
  assign busy_active = active;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rdata <= 16'h0000;
    else if (rd)
    begin
      if (addr == RMBC_REG_OPTS)
        rdata <= opts_reg;
      else if (addr == RMBC_REG_VAR0)
        rdata <= ctl_var[0];
      else if (addr == RMBC_REG_VAR1)
        rdata <= ctl_var[1];
      else if (addr == RMBC_REG_STATUS)
        rdata <= {9'h000, second_area, switched, rx_pending, rt_busy,
          need_reprog, file_patch, active};
      else if (addr == RMBC_REG_WORD4)
        rdata <= word4;
      else
        rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [verif/rmbc_unit_model.sv]
`default_nettype none
module rmbc_unit_model
(
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [3:0] dly,
  input wire logic [3:0] kind,
  output rmbc_pkg::rmbc_resp_t resp
);
  timeunit 1ns;
  timeprecision 1ns;
  import rmbc_pkg::*;
  logic [3:0] cnt = 4'h0;
  logic armed = 1'b0;
  initial
    resp = '0;
  // Between replies the words swing every cycle, so stale data never match.
  always @(posedge clk_sys)
  begin
    resp.valid <= 1'b0;
    resp.status_word <= ~resp.status_word;
    resp.data_word <= ~resp.data_word;
    if (go)
    begin
      cnt <= dly;
      armed <= 1'b1;
    end
    else if (armed && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (armed)
    begin
      armed <= 1'b0;
      resp <= '{1'b1, kind[2], kind[3], {12'h000, kind[1], 3'h0},
        {kind[0], 15'h0155}};
    end
  end
endmodule
`default_nettype wire

// [verif/rmbc_checker.sv]
`default_nettype none
module rmbc_checker
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wr,
  input wire logic hdr_valid,
  input wire logic [1:0] hdr_tc,
  input wire logic msg_req,
  input wire rmbc_pkg::rmbc_msg_t msg_kind,
  input wire logic is_verify,
  input wire logic [15:0] word4,
  input wire rmbc_pkg::rmbc_resp_t resp,
  input wire logic bus_fail,
  input wire logic rt_busy,
  input wire logic discard_data,
  input wire logic resend_rx,
  input wire logic use_redundant,
  input wire logic busy_active
);
  timeunit 1ns;
  timeprecision 1ns;
  import rmbc_pkg::*;
  logic [1:0] last_tc;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      last_tc <= 2'h0;
    else if (hdr_valid)
      last_tc <= hdr_tc;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_busy_discard: assert property (
    resp.valid && resp.status_word[3] |=> discard_data && rt_busy)
    else $error("busy status not honoured");
  a_both_clear: assert property (
    resp.valid && resp.is_activity && !resp.status_word[3]
    && !resp.data_word[15] |=> !rt_busy) else $error("busy not cleared");
  a_resend_pulse: assert property (resend_rx |=> !resend_rx)
    else $error("resend longer than one cycle");
  a_end_lv_zero: assert property (
    msg_req && msg_kind inside {RMBC_MSG_END_LOAD, RMBC_MSG_END_VERIFY}
    |=> word4[9:8] == 2'h0) else $error("load verify field not zero");
  a_verify_area: assert property (
    msg_req && is_verify |=> word4[7:4] == 4'h0)
    else $error("area bits set in verify");
  a_tc_verify: assert property (
    msg_req && msg_kind != RMBC_MSG_END_VERIFY |=> !word4[0])
    else $error("transfer bit outside verify end");
  a_tc10_clear: assert property (
    msg_req && msg_kind == RMBC_MSG_END_VERIFY && last_tc == RMBC_TC_XFER
    |=> word4[9:0] == 10'h000) else $error("low bits not cleared");
  a_switch_cause: assert property (
    $rose(use_redundant) |-> $past(bus_fail))
    else $error("switch without bus failure");
  a_one_switch: assert property (
    use_redundant && busy_active && !wr |=> use_redundant)
    else $error("switched back");
endmodule
bind rmbc_ctl rmbc_checker u_chk
(
  .clk_sys(clk_sys), .reset(reset), .wr(wr), .hdr_valid(hdr_valid),
  .hdr_tc(hdr_tc), .msg_req(msg_req), .msg_kind(msg_kind),
  .is_verify(is_verify), .word4(word4), .resp(resp), .bus_fail(bus_fail),
  .rt_busy(rt_busy), .discard_data(discard_data), .resend_rx(resend_rx),
  .use_redundant(use_redundant), .busy_active(busy_active)
);
`default_nettype wire

// [verif/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rmbc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, word4;
  logic [15:0] nom_word [3];
  logic wr = 1'b0, rd = 1'b0, msg_req = 1'b0, go = 1'b0;
  logic patch_ex = 1'b1, full_ex = 1'b1, hdr_valid = 1'b0;
  logic act_as_bc = 1'b0, is_verify = 1'b0, bus_fail = 1'b0;
  logic [1:0] hdr_tc = 2'h0;
  logic [3:0] dly = 4'h0, kind = 4'h0;
  rmbc_msg_t msg_kind = RMBC_MSG_FIRST_LOAD;
  rmbc_resp_t resp;
  logic rt_busy, discard_data, resend_rx, use_redundant, busy_active;
  logic file_patch, file_full, need_reprog;
  logic [3:0] red_conn;
  int failures = 0, n_checks = 0, cyc = 0;
  rmbc_ctl dut
  (
    .clk_sys, .reset, .addr, .wdata, .wr, .rd, .rdata,
    .patch_exists(patch_ex), .full_exists(full_ex), .hdr_valid, .hdr_tc,
    .msg_req, .msg_kind, .act_as_bc, .is_verify, .nom_word, .word4, .resp,
    .bus_fail, .rt_busy, .discard_data, .resend_rx, .use_redundant,
    .red_conn, .file_patch, .file_full, .need_reprog, .busy_active
  );
  rmbc_unit_model far_end
  (
    .clk_sys, .go, .dly, .kind, .resp
  );
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic start(input logic [15:0] opts);
    wr_reg(RMBC_REG_CTRL, 16'h0002);
    wr_reg(RMBC_REG_OPTS, opts);
    wr_reg(RMBC_REG_CTRL, 16'h0001);
    chk("active", {15'h0, busy_active}, 16'h0001);
  endtask
  task automatic hdr(input logic [1:0] tc);
    @(posedge clk_sys);
    hdr_tc <= tc;
    hdr_valid <= 1'b1;
    @(posedge clk_sys);
    hdr_valid <= 1'b0;
  endtask
  task automatic msg(input rmbc_msg_t k, input logic bc, input logic ver);
    @(posedge clk_sys);
    msg_kind <= k;
    act_as_bc <= bc;
    is_verify <= ver;
    msg_req <= 1'b1;
    @(posedge clk_sys);
    msg_req <= 1'b0;
    #1;
  endtask
  task automatic respond(input logic [3:0] k, input logic [3:0] d);
    @(posedge clk_sys);
    kind <= k;
    dly <= d;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    for (int i = 0; i < 20 && resp.valid !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
  endtask
  task automatic fail_bus();
    @(posedge clk_sys);
    bus_fail <= 1'b1;
    @(posedge clk_sys);
    bus_fail <= 1'b0;
    #1;
  endtask
  task automatic t_regs();
    logic [15:0] v;
    rd_reg(RMBC_REG_OPTS, v);
    chk("opts reset", v, RMBC_OPTS_RESET);
    for (int i = 0; i < 6; i++)
      wr_reg(RMBC_REG_RT_NOM0 + 8'(4 * i), 16'(16'h1111 * (i + 1)));
    wr_reg(RMBC_REG_VAR0, 16'hffff);
    wr_reg(RMBC_REG_VAR1, 16'h54c0);
    wr_reg(8'hfc, 16'hffff);
    rd_reg(8'hfc, v);
    chk("unmapped", v, 16'h0000);
    rd_reg(RMBC_REG_VAR0, v);
    chk("var0", v, 16'hffff);
    $display("test regs done");
  endtask
  task automatic t_word4();
    logic [15:0] v;
    start(16'h2a00);
    msg(RMBC_MSG_FIRST_LOAD, 1'b1, 1'b0);
    chk("first load", word4 & 16'hfcf1, 16'hfcc0);
    msg(RMBC_MSG_FIRST_LOAD, 1'b1, 1'b0);
    chk("later load", word4 & 16'hfcf1, 16'hfc00);
    for (int i = 0; i < 3; i++)
      chk("rt nom", nom_word[i], 16'(16'h1111 * (i + 1)));
    hdr(RMBC_TC_END);
    msg(RMBC_MSG_END_LOAD, 1'b0, 1'b0);
    chk("end load", word4 & 16'hfff1, 16'hfc30);
    for (int i = 0; i < 3; i++)
      chk("bc nom", nom_word[i], 16'(16'h1111 * (i + 4)));
    msg(RMBC_MSG_END_VERIFY, 1'b1, 1'b1);
    chk("end verify", word4 & 16'hfff1, 16'hfc01);
    hdr(RMBC_TC_XFER);
    msg(RMBC_MSG_END_VERIFY, 1'b1, 1'b1);
    chk("verify xfer", word4, 16'hfc00);
    msg(RMBC_MSG_FIRST_LOAD, 1'b1, 1'b1);
    chk("verify first", word4 & 16'hfcf1, 16'hfc00);
    msg(RMBC_MSG_BC_TAKEOVER, 1'b0, 1'b0);
    chk("takeover fill", word4 & 16'hfc00, 16'ha800);
    rd_reg(RMBC_REG_WORD4, v);
    chk("word4 reg", v, 16'ha800);
    $display("test word4 done");
  endtask
  task automatic t_simul();
    start(16'h8000);
    msg(RMBC_MSG_FIRST_LOAD, 1'b1, 1'b0);
    chk("area one", word4 & 16'hfcf1, 16'hfcc0);
    hdr(RMBC_TC_END);
    msg(RMBC_MSG_END_LOAD, 1'b1, 1'b0);
    msg(RMBC_MSG_FIRST_LOAD, 1'b1, 1'b0);
    chk("area two", word4 & 16'hfcf1, 16'h54c0);
    $display("test simul done");
  endtask
  task automatic t_busy();
    start(16'h0001);
    respond(4'b0110, 4'h0);
    chk("sw busy", {14'h0, rt_busy, discard_data}, 16'h0003);
    respond(4'b0101, 4'h3);
    chk("dw ignored", {15'h0, rt_busy}, 16'h0000);
    start(16'h0000);
    respond(4'b0101, 4'h0);
    chk("dw busy", {15'h0, rt_busy}, 16'h0001);
    respond(4'b0100, 4'h9);
    chk("both clear", {15'h0, rt_busy}, 16'h0000);
    $display("test busy done");
  endtask
  task automatic t_rx();
    for (int c = 0; c < 2; c++)
    begin
      start(16'(16'h0001 + 2 * c));
      respond(4'b1010, 4'h1);
      respond(4'b0100, 4'h0);
      chk("resend", {15'h0, resend_rx}, 16'(1 - c));
    end
    $display("test rx done");
  endtask
  task automatic t_red();
    logic [15:0] v;
    start(16'h0094);
    chk("conn", {12'h0, red_conn}, 16'h0009);
    chk("no switch", {15'h0, use_redundant}, 16'h0000);
    fail_bus();
    fail_bus();
    chk("switched", {15'h0, use_redundant}, 16'h0001);
    rd_reg(RMBC_REG_STATUS, v);
    chk("status", v & 16'h0021, 16'h0021);
    start(16'h0054);
    chk("warfare conn", {12'h0, red_conn}, 16'h0005);
    fail_bus();
    fail_bus();
    chk("one switch", {15'h0, use_redundant}, 16'h0001);
    start(16'h0074);
    chk("unused sel", {12'h0, red_conn}, 16'h0000);
    start(16'h0090);
    fail_bus();
    chk("disabled", {8'h0, red_conn, 3'h0, use_redundant}, 16'h0000);
    $display("test redundant done");
  endtask
  task automatic t_files();
    start(16'h0000);
    chk("patch first", {14'h0, file_patch, file_full}, 16'h0002);
    @(posedge clk_sys);
    patch_ex <= 1'b0;
    start(16'h0000);
    chk("full only", {14'h0, file_patch, file_full}, 16'h0001);
    wr_reg(RMBC_REG_CFG_CMP0, 16'h1234);
    wr_reg(RMBC_REG_CMP_IN, 16'h1235);
    start(16'h4000);
    chk("reprog", {15'h0, need_reprog}, 16'h0001);
    wr_reg(RMBC_REG_CMP_IN, 16'h1234);
    start(16'h4000);
    chk("no reprog", {15'h0, need_reprog}, 16'h0000);
    $display("test files done");
  endtask
  initial
    forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures = failures + 1;
      complete_run();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_word4();
    t_simul();
    t_busy();
    t_rx();
    t_red();
    t_files();
    complete_run();
  end
endmodule
`default_nettype wire
